// File: rtl/cmi_pkg.sv
/*
  Constants shared by the coherent memory interleave decoder: address
  field positions (bit 0 is the most significant address bit), span
  encodings and local alias region masks.
  Assumes one clock domain; all configuration comes in on plain ports.
*/
// What this block does
// R1 - every coherent reference gets board, bus, bank; board picks ring pair
// R2 - board pairs, per-row bus span, bank span come from configuration
// R3 - generated board not marked present raises high priority machine check
// R4 - row configuration confirms the referenced memory row is installed
// R5 - alias region ends at 0x1FFFFFF, 0x3FFFFFF or 0x7FFFFFF; 128 Mbyte default
// R6 - node from configuration when size nonzero and upper address bits zero
// R7 - coherency operations inside the region carry node number zero
// R8 - original node number must be zero for blocks inside the region
// R9 - region hit with nonzero original node raises machine check
// R10 - lines rotate across boards, then buses, then banks from the base
// R11 - interleave base bits not used as base values must be zero
// R12 - one board pair: base bits taken from the interleave base field
// R13 - two board pairs: base bits shift one place toward bit 0
// R14 - four board pairs: base bits shift two places toward bit 0
// R15 - one board pair: index bits taken from page offset field
// R16 - two board pairs: index bits shift one place toward bit 0
// R17 - four board pairs: eight buses four banks uses lower page bit 10
// R18 - board equals base plus index modulo 2, 4 or 8 boards
// R19 - bus equals base plus index mod 4 within group, or mod 8
// R20 - bank equals base plus index modulo two or four
// R21 - 40-bit address decoded with bit 0 most significant
// R22 - all results and errors registered one cycle after the request
`default_nettype none

package cmi_pkg;

  localparam int ADDR_W = 40;
  localparam int NODE_W = 5;

  // field positions, bit 0 most significant
  localparam int NODE_LO  = 0;
  localparam int NODE_HI  = 4;
  localparam int UPAGE_LO = 5;
  localparam int UPAGE_HI = 6;
  localparam int ROW_LO   = 7;
  localparam int ROW_HI   = 8;
  localparam int BASE_LO  = 9;
  localparam int BASE_HI  = 16;
  localparam int LPAGE_LO = 17;
  localparam int LPAGE_HI = 27;
  localparam int OFFS_LO  = 28;
  localparam int OFFS_HI  = 34;

  // board pair span encodings
  localparam logic [1:0] PAIRS_ONE  = 2'h0;
  localparam logic [1:0] PAIRS_TWO  = 2'h1;
  localparam logic [1:0] PAIRS_FOUR = 2'h2;

  // alias region size encodings
  localparam logic [1:0] ALIAS_OFF = 2'h0;
  localparam logic [1:0] ALIAS_32M = 2'h1;
  localparam logic [1:0] ALIAS_64M = 2'h2;
  localparam logic [1:0] ALIAS_128M = 2'h3;
  localparam logic [1:0] ALIAS_DEFAULT = ALIAS_128M;

  // interleave base bits that must be zero for an alias hit;
  // bit 7 of the mask is interleave base bit 0
  localparam logic [7:0] ALIAS_MASK_32M  = 8'hFC;
  localparam logic [7:0] ALIAS_MASK_64M  = 8'hF8;
  localparam logic [7:0] ALIAS_MASK_128M = 8'hF0;

  localparam logic [7:0] BASE_GROUP_BIT = 8'h80;
  localparam logic [2:0] BUS_BITS_FOUR  = 3'h2;
  localparam logic [2:0] BUS_BITS_EIGHT = 3'h3;

endpackage : cmi_pkg

`default_nettype wire

// File: rtl/cmi_rotate.sv
/*
  Rotation adder: base plus index modulo the span given by a mask.
  Bits of the base above the span pass through unchanged, which keeps a
  four-bus span inside its lower or upper group.
  Assumes base and index arrive already extracted; purely combinational.
*/
`default_nettype none

module cmi_rotate #(
  parameter int W = 3
) (
  input  wire logic [W-1:0] base,
  input  wire logic [W-1:0] index,
  input  wire logic [W-1:0] spanMask,
  output logic      [W-1:0] result
);

  logic [W-1:0] sum;

  assign sum    = base + index;                            // R10
  assign result = (sum & spanMask) | (base & ~spanMask);   // R19

endmodule // cmi_rotate

`default_nettype wire

// File: rtl/cmi_decoder.sv
/*
  Coherent memory interleave decoder. Splits a 40-bit coherent address,
  picks board, bus and bank base values from the interleave base field
  and index values from the page offset field, rotates them through the
  configured spans, substitutes the local node number, or node zero for
  coherency operations, in the low alias region and flags machine check
  conditions. Results are registered.
  Assumes request and configuration ports come from logic on mclk.
*/
`default_nettype none

module cmi_decoder
  import cmi_pkg::*;
#(
  parameter int BOARDS = 8,
  parameter int ROWS   = 4
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                clkEn,
  input  wire logic                reqValid,
  input  wire logic [0:ADDR_W-1]   reqAddr,
  input  wire logic                reqCoherent,
  input  wire logic [1:0]          cfgBoardPairs,
  input  wire logic [ROWS-1:0]     cfgBusEight,
  input  wire logic [ROWS-1:0]     cfgBankFour,
  input  wire logic [ROWS-1:0]     cfgRowPresent,
  input  wire logic [BOARDS-1:0]   cfgBoardPresent,
  input  wire logic [NODE_W-1:0]   cfgNodeNumber,
  input  wire logic [1:0]          cfgAliasSize,
  output logic                     rspValid,
  output logic [2:0]               rspBoard,
  output logic [2:0]               rspBus,
  output logic [1:0]               rspBank,
  output logic [1:0]               rspRow,
  output logic [NODE_W-1:0]        rspNode,
  output logic                     rspBoardErr,
  output logic                     rspRowErr,
  output logic                     rspBaseErr,
  output logic                     rspNodeErr,
  output logic                     rspConfigErr,
  output logic                     rspMachineCheck
);

  // address fields
  logic [NODE_W-1:0] origNode;
  logic [1:0]        upperPage;
  logic [1:0]        row;
  logic [7:0]        baseVal;
  logic [7:0]        offVal;

  assign origNode  = reqAddr[NODE_LO:NODE_HI];                   // R21
  assign upperPage = reqAddr[UPAGE_LO:UPAGE_HI];                 // R21
  assign row       = reqAddr[ROW_LO:ROW_HI];                     // R21
  // baseVal[7] is interleave base bit 0, baseVal[0] is bit 7
  assign baseVal   = reqAddr[BASE_LO:BASE_HI];                   // R21
  // lower page bit 10 sits just above page offset bit 0
  assign offVal    = {reqAddr[LPAGE_HI], reqAddr[OFFS_LO:OFFS_HI]}; // R21

  // configuration for the accessed row
  logic       rowEight;
  logic       rowBankFour;
  logic       pairsBad;
  logic [2:0] boardBits;
  logic [2:0] busBits;
  logic [2:0] bankBits;
  logic [2:0] bankShift;

  assign rowEight    = cfgBusEight[row];                         // R2
  assign rowBankFour = cfgBankFour[row];                         // R2
  assign pairsBad    = (cfgBoardPairs != PAIRS_ONE) &&
                       (cfgBoardPairs != PAIRS_TWO) &&
                       (cfgBoardPairs != PAIRS_FOUR);            // R2
  // one, two or four pairs span 2, 4 or 8 boards
  assign boardBits   = {1'h0, cfgBoardPairs} + 3'h1;             // R18
  assign busBits     = rowEight ? BUS_BITS_EIGHT : BUS_BITS_FOUR;
  assign bankBits    = rowBankFour ? 3'h2 : 3'h1;                // R20
  // bank field sits directly above the contiguous bus bits
  assign bankShift   = boardBits + busBits;                      // R10

  // span masks
  logic [7:0] boardMask;
  logic [7:0] busLowMask;
  logic [7:0] bankMask;

  assign boardMask  = ~(8'hFF << boardBits);                     // R18
  assign busLowMask = ~(8'hFF << busBits);                       // R19
  assign bankMask   = ~(8'hFF << bankBits);                      // R20

  // base selection: low contiguous bits of the interleave base field
  logic [7:0] baseBusSh;
  logic [7:0] baseBankSh;
  logic [2:0] boardBase;
  logic [2:0] busBase;
  logic [1:0] bankBase;

  assign baseBusSh  = baseVal >> boardBits;                      // R12 R13 R14
  assign baseBankSh = baseVal >> bankShift;                      // R12 R13 R14
  assign boardBase  = baseVal[2:0] & boardMask[2:0];             // R12 R13 R14
  // a four-bus span takes its group from interleave base bit 0
  assign busBase    = rowEight ? baseBusSh[2:0]
                               : {baseVal[7], baseBusSh[1:0]};   // R12 R13 R14
  assign bankBase   = baseBankSh[1:0] & bankMask[1:0];           // R12 R13 R14

  // index selection: low bits of page offset, then lower page bit 10
  logic [7:0] offBusSh;
  logic [7:0] offBankSh;
  logic [2:0] boardIdx;
  logic [2:0] busIdx;
  logic [1:0] bankIdx;

  assign offBusSh  = offVal >> boardBits;                        // R15 R16 R17
  assign offBankSh = offVal >> bankShift;                        // R15 R16 R17
  assign boardIdx  = offVal[2:0] & boardMask[2:0];               // R15 R16 R17
  assign busIdx    = offBusSh[2:0] & busLowMask[2:0];            // R15 R16 R17
  assign bankIdx   = offBankSh[1:0] & bankMask[1:0];             // R15 R16 R17

  // unused interleave base bits must be zero
  logic [7:0] baseUsed;
  logic       baseErr;

  assign baseUsed = boardMask
                  | (busLowMask << boardBits)
                  | (bankMask << bankShift)
                  | (rowEight ? 8'h00 : BASE_GROUP_BIT);         // R11
  assign baseErr  = |(baseVal & ~baseUsed);                      // R11

  // rotation
  logic [2:0] boardNum;
  logic [2:0] busNum;
  logic [1:0] bankNum;

  cmi_rotate #(.W(3)) uBoardRot (
    .base     (boardBase),
    .index    (boardIdx),
    .spanMask (boardMask[2:0]),
    .result   (boardNum)
  );                                                             // R18

  cmi_rotate #(.W(3)) uBusRot (
    .base     (busBase),
    .index    (busIdx),
    .spanMask (busLowMask[2:0]),
    .result   (busNum)
  );                                                             // R19

  cmi_rotate #(.W(2)) uBankRot (
    .base     (bankBase),
    .index    (bankIdx),
    .spanMask (bankMask[1:0]),
    .result   (bankNum)
  );                                                             // R20

  // presence checks; board number doubles as the ring pair number
  logic boardErr;
  logic rowErr;

  assign boardErr = !cfgBoardPresent[boardNum];                  // R3 R1
  assign rowErr   = !cfgRowPresent[row];                         // R4

  // local alias region
  logic [7:0]        aliasMask;
  logic              aliasHit;
  logic              nodeErr;
  logic [NODE_W-1:0] nodeNum;

  assign aliasMask = (cfgAliasSize == ALIAS_32M) ? ALIAS_MASK_32M :
                     (cfgAliasSize == ALIAS_64M) ? ALIAS_MASK_64M :
                                                   ALIAS_MASK_128M; // R5
  assign aliasHit  = (cfgAliasSize != ALIAS_OFF) &&
                     (upperPage == 2'h0) && (row == 2'h0) &&
                     ((baseVal & aliasMask) == 8'h00);           // R6
  // the original node must be zero before it is replaced
  assign nodeErr   = aliasHit && (origNode != '0);               // R8 R9
  // coherency traffic to processors carries node zero in the region
  assign nodeNum   = !aliasHit   ? origNode :
                     reqCoherent ? '0 : cfgNodeNumber;           // R6 R7

  logic anyErr;

  assign anyErr = boardErr | rowErr | baseErr | nodeErr | pairsBad; // R3 R9

  // results register together, one cycle after the request
  logic              validFf;
  logic [2:0]        boardFf;
  logic [2:0]        busFf;
  logic [1:0]        bankFf;
  logic [1:0]        rowFf;
  logic [NODE_W-1:0] nodeFf;
  logic [5:0]        errFf;

  always_ff @(posedge mclk) begin
    if (reset) begin
      validFf <= 1'b0;
      boardFf <= 3'h0;
      busFf   <= 3'h0;
      bankFf  <= 2'h0;
      rowFf   <= 2'h0;
      nodeFf  <= '0;
      errFf   <= 6'h00;
    end else if (clkEn) begin
      validFf <= reqValid;                                       // R22
      if (reqValid) begin
        boardFf <= boardNum;                                     // R22
        busFf   <= busNum;
        bankFf  <= bankNum;
        rowFf   <= row;
        nodeFf  <= nodeNum;
        errFf   <= {anyErr, pairsBad, nodeErr, baseErr, rowErr, boardErr};
      end
    end
  end

  assign rspValid        = validFf;
  assign rspBoard        = boardFf;
  assign rspBus          = busFf;
  assign rspBank         = bankFf;
  assign rspRow          = rowFf;
  assign rspNode         = nodeFf;
  assign rspBoardErr     = errFf[0];
  assign rspRowErr       = errFf[1];
  assign rspBaseErr      = errFf[2];
  assign rspNodeErr      = errFf[3];
  assign rspConfigErr    = errFf[4];
  assign rspMachineCheck = errFf[5];

endmodule // cmi_decoder

`default_nettype wire

// File: verif/cmi_decoder_properties.sv
/* Port checker for cmi_decoder: timing and decode relations.
   Assumes a bind onto cmi_decoder; one clock, sync reset. */
`default_nettype none
module cmi_decoder_checker
  import cmi_pkg::*;
#(
  parameter int BOARDS = 8,
  parameter int ROWS   = 4
) (
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              clkEn,
  input wire logic              reqValid,
  input wire logic [0:ADDR_W-1] reqAddr,
  input wire logic              reqCoherent,
  input wire logic [1:0]        cfgBoardPairs,
  input wire logic [ROWS-1:0]   cfgRowPresent,
  input wire logic [BOARDS-1:0] cfgBoardPresent,
  input wire logic [1:0]        cfgAliasSize,
  input wire logic              rspValid,
  input wire logic [2:0]        rspBoard,
  input wire logic [2:0]        rspBus,
  input wire logic [1:0]        rspBank,
  input wire logic [1:0]        rspRow,
  input wire logic [NODE_W-1:0] rspNode,
  input wire logic              rspBoardErr,
  input wire logic              rspRowErr,
  input wire logic              rspBaseErr,
  input wire logic              rspNodeErr,
  input wire logic              rspConfigErr,
  input wire logic              rspMachineCheck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic              rowOk_ff;
  logic              pairX_ff;
  logic [BOARDS-1:0] pres_ff;
  logic [4:0]        orig_ff;
  logic [1:0]        row_ff;
  wire logic         take = clkEn && reqValid;
  // copies of the request taken, so checks see what the design saw
  always_ff @(posedge mclk) if (!reset && take) begin
    rowOk_ff <= cfgRowPresent[reqAddr[7:8]];
    pairX_ff <= reqAddr[16] ^ reqAddr[34];
    pres_ff  <= cfgBoardPresent;
    orig_ff  <= reqAddr[0:4];
    row_ff   <= reqAddr[7:8];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_valid; clkEn |=> rspValid == $past(reqValid); endproperty
  a_valid: assert property (p_valid) else $error("valid lag");
  property p_freeze;
    !clkEn |=> $stable(rspValid) && $stable(rspBoard) && $stable(rspNode);
  endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");
  property p_hold;
    clkEn && !reqValid |=> $stable(rspBus) && $stable(rspBank)
      && $stable(rspRow);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_cfg;
    take |=> rspConfigErr == ($past(cfgBoardPairs) == 2'h3);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config flag");
  property p_mc;
    rspValid |-> rspMachineCheck == (rspBoardErr || rspRowErr
      || rspBaseErr || rspNodeErr || rspConfigErr);
  endproperty
  a_mc: assert property (p_mc) else $error("machine check");
  property p_row;
    rspValid |-> rspRow == row_ff && rspRowErr == !rowOk_ff;
  endproperty
  a_row: assert property (p_row) else $error("row check");
  property p_board; rspValid |-> rspBoardErr == !pres_ff[rspBoard];
  endproperty
  a_board: assert property (p_board) else $error("board flag");
  property p_one_pair;
    take && cfgBoardPairs == 2'h0 |=> rspBoard == {2'h0, pairX_ff};
  endproperty
  a_one_pair: assert property (p_one_pair) else $error("board");
  property p_alias;
    take && cfgAliasSize != 2'h0 && reqAddr[5:14] == 10'h0 && reqCoherent
      |=> rspNode == 5'h0 && rspNodeErr == (orig_ff != 5'h0);
  endproperty
  a_alias: assert property (p_alias) else $error("alias node");
  property p_noalias;
    take && cfgAliasSize == 2'h0 |=> rspNode == orig_ff && !rspNodeErr;
  endproperty
  a_noalias: assert property (p_noalias) else $error("node");
  c_alias: cover property (rspValid && rspNodeErr);
  c_board: cover property (rspValid && rspBoardErr);
  c_cfg: cover property (rspValid && rspConfigErr);
endmodule // cmi_decoder_checker
`default_nettype wire

// File: verif/cmi_board_sink.sv
/* Memory board side stand-in: takes a response only after an enabled
   edge, since a frozen valid is no new line. Assumes mclk outputs. */
`default_nettype none
module cmi_board_sink (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clkEn,
  input  wire logic rspValid,
  output logic      fresh
);
  timeunit 1ns;
  timeprecision 1ns;
  logic enQ_ff;
  always_ff @(posedge mclk) enQ_ff <= clkEn && !reset;
  assign fresh = rspValid && enQ_ff;
endmodule // cmi_board_sink
`default_nettype wire

// File: verif/cmi_decoder_test.sv
/* Self-checking bench for cmi_decoder: random requests and settings
   against a reference decode. Assumes checker and sink compiled. */
`default_nettype none
module cmi_decoder_test
  import cmi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset, clkEn, reqValid, reqCoherent;
  logic [0:39] reqAddr;
  logic [1:0] cfgBoardPairs, cfgAliasSize;
  logic [3:0] cfgBusEight, cfgBankFour, cfgRowPresent;
  logic [7:0] cfgBoardPresent;
  logic [4:0] cfgNodeNumber;
  wire logic rspValid, rspBoardErr, rspRowErr, rspBaseErr, rspNodeErr;
  wire logic rspConfigErr, rspMachineCheck, fresh;
  wire logic [2:0] rspBoard, rspBus;
  wire logic [1:0] rspBank, rspRow;
  wire logic [4:0] rspNode;
  wire logic [20:0] got = {rspBoard, rspBus, rspBank, rspRow, rspNode,
    rspBoardErr, rspRowErr, rspBaseErr, rspNodeErr, rspConfigErr,
    rspMachineCheck};
  int miscompares, nTests;
  logic [21:0] q[$];
  cmi_decoder cmi_decoder_i (.mclk(mclk), .reset(reset), .clkEn(clkEn),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqCoherent(reqCoherent),
    .cfgBoardPairs(cfgBoardPairs), .cfgBusEight(cfgBusEight),
    .cfgBankFour(cfgBankFour), .cfgRowPresent(cfgRowPresent),
    .cfgBoardPresent(cfgBoardPresent), .cfgNodeNumber(cfgNodeNumber),
    .cfgAliasSize(cfgAliasSize), .rspValid(rspValid), .rspBoard(rspBoard),
    .rspBus(rspBus), .rspBank(rspBank), .rspRow(rspRow), .rspNode(rspNode),
    .rspBoardErr(rspBoardErr), .rspRowErr(rspRowErr),
    .rspBaseErr(rspBaseErr), .rspNodeErr(rspNodeErr),
    .rspConfigErr(rspConfigErr), .rspMachineCheck(rspMachineCheck));
  cmi_board_sink cmi_board_sink_i (.mclk(mclk), .reset(reset),
    .clkEn(clkEn), .rspValid(rspValid), .fresh(fresh));
  function automatic logic [20:0] expect_f();
    int b, s, k;
    logic [7:0] bv, ov, u;
    logic [2:0] bd, bb, bu;
    logic [1:0] r, kk;
    logic [4:0] o, nd;
    logic h, e0, e1, e2, e3, e4;
    bv = reqAddr[9:16];
    ov = {reqAddr[27], reqAddr[28:34]};
    r = reqAddr[7:8];
    o = reqAddr[0:4];
    b = cfgBoardPairs + 1;
    s = cfgBusEight[r] ? 3 : 2;
    k = cfgBankFour[r] ? 2 : 1;
    bd = 3'((bv + ov) & ((8'h1 << b) - 8'h1));
    if (b == 1) bd[2:1] = 2'h0;
    bb = 3'(bv >> b) + 3'(ov >> b);
    bu = (s == 3) ? bb : {bv[7], bb[1:0]};
    kk = 2'(bv >> (b + s)) + 2'(ov >> (b + s));
    if (k == 1) kk[1] = 1'h0;
    u = (8'h1 << (b + s + k)) - 8'h1;
    if (s == 2) u[7] = 1'h1;
    h = cfgAliasSize != 2'h0 && reqAddr[5:8] == 4'h0
      && (bv >> (cfgAliasSize + 1)) == 8'h0;
    nd = h ? (reqCoherent ? 5'h0 : cfgNodeNumber) : o;
    e0 = !cfgBoardPresent[bd];
    e1 = !cfgRowPresent[r];
    e2 = |(bv & ~u);
    e3 = h && o != 5'h0;
    e4 = cfgBoardPairs == 2'h3;
    return {bd, bu, kk, r, nd, e0, e1, e2, e3, e4, e0|e1|e2|e3|e4};
  endfunction
  task automatic chk(logic [20:0] e, logic [20:0] g);
    nTests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t decode exp %h got %h", $time, e, g);
    end
  endtask
  task automatic close_out();
    $display("tests %0d miscompares %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // an illegal pair span only promises the config and check flags
  always @(negedge mclk) if (fresh) begin
    logic [21:0] e;
    if (q.size() == 0) chk(21'h0, ~got);
    else begin
      e = q.pop_front();
      if (e[21]) e[20:2] = got[20:2];
      chk({e[20:6], got[5:0]}, got);
      chk({got[20:6], e[5:0]}, got);
    end
  end
  initial begin
    {clkEn, reqValid, reqCoherent, reqAddr, cfgBoardPairs} = '0;
    {cfgBusEight, cfgBankFour, cfgRowPresent, cfgNodeNumber} = '0;
    cfgAliasSize = ALIAS_DEFAULT;
    cfgBoardPresent = 8'hFF;
    reset = 1'h1;
    void'($urandom(40855));
    repeat (20) @(negedge mclk);
    reset = 1'h0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge mclk);
      reqAddr = {$urandom, 8'($urandom)};
      if (1'($urandom)) reqAddr[5:14] = 10'h0;
      if (1'($urandom)) reqAddr[0:4] = 5'h0;
      {cfgBoardPairs, cfgAliasSize, cfgBusEight, cfgBankFour} = 12'($urandom);
      cfgRowPresent = ~(4'h1 << ($urandom % 6));
      cfgBoardPresent = ~(8'h1 << ($urandom % 12));
      {cfgNodeNumber, reqCoherent} = 6'($urandom);
      clkEn = ($urandom % 8) != 0;
      reqValid = ($urandom % 4) != 0;
      if (clkEn && reqValid) begin
        q.push_back({cfgBoardPairs == 2'h3, expect_f()});
      end
    end
    @(negedge mclk);
    reqValid = 1'h0;
    repeat (3) @(negedge mclk);
    chk(21'(q.size()), 21'h0);
    close_out();
  end
  // the main run takes about 3030 cycles
  initial begin
    repeat (4000) @(posedge mclk);
    miscompares++;
    close_out();
  end
endmodule // cmi_decoder_test
bind cmi_decoder cmi_decoder_checker #(.BOARDS(BOARDS), .ROWS(ROWS))
  cmi_decoder_checker_i (.mclk(mclk), .reset(reset), .clkEn(clkEn),
  .reqValid(reqValid), .reqAddr(reqAddr), .reqCoherent(reqCoherent),
  .cfgBoardPairs(cfgBoardPairs), .cfgRowPresent(cfgRowPresent),
  .cfgBoardPresent(cfgBoardPresent), .cfgAliasSize(cfgAliasSize),
  .rspValid(rspValid), .rspBoard(rspBoard), .rspBus(rspBus),
  .rspBank(rspBank), .rspRow(rspRow), .rspNode(rspNode),
  .rspBoardErr(rspBoardErr), .rspRowErr(rspRowErr),
  .rspBaseErr(rspBaseErr), .rspNodeErr(rspNodeErr),
  .rspConfigErr(rspConfigErr), .rspMachineCheck(rspMachineCheck));
`default_nettype wire
